// ==== dv/core_ack_model.sv ====
// processor core model issuing level acknowledges
module core_ack_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // commands from the bench
    input wire logic go_i,
    input wire logic [2:0] num_i,
    input wire logic sw_i,
    // acknowledge to the block
    output logic ack_o,
    output logic [2:0] num_o,
    output logic svc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ack_o <= 1'b0;
            num_o <= 3'h0;
            svc_o <= 1'b0;
        end else begin
            ack_o <= go_i;
            num_o <= num_i;
            svc_o <= go_i & sw_i;
        end
    end
endmodule // core_ack_model

// ==== dv/peripheral_interrupt_vectoring_assertions.sv ====
// port-level checks of the vectoring block
module pivec_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // sources
    input wire logic power_drive_fault_request_i,
    input wire logic compare_one_request_i,
    input wire logic timer_two_period_request_i,
    input wire logic timer_two_compare_request_i,
    input wire logic capture_one_request_i,
    input wire logic nmi_pin_request_i,
    // core side
    input wire logic [5:0] level_mask_register_i,
    input wire logic level_ack_i,
    input wire logic [2:0] level_ack_num_i,
    input wire logic level_service_instruction_i,
    input wire logic [5:0] level_request_o,
    input wire logic nmi_request_o,
    input wire logic [15:0] level_location_o,
    input wire logic ack_taken_o,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ========================================
    // assertions
    a_nmi_route: assert property (!$past(srst_i) |-> nmi_request_o == $past(nmi_pin_request_i))
        else $error("nmi request not one cycle late");
    a_group_levels: assert property (!$past(srst_i) |-> level_request_o[3:1] ==
        {$past(capture_one_request_i), $past(timer_two_period_request_i | timer_two_compare_request_i),
        $past(power_drive_fault_request_i | compare_one_request_i)}) else $error("group level request wrong");
    a_taken_cause: assert property (ack_taken_o |-> $past(level_ack_i))
        else $error("ack taken without acknowledge");
    a_level_location: assert property (ack_taken_o |->
        level_location_o == 16'h0002 + 16'({$past(level_ack_num_i), 1'b0})) else $error("bad location");
    a_masked_refused: assert property (level_ack_i && !level_service_instruction_i &&
        !level_mask_register_i[level_ack_num_i] |=> !ack_taken_o) else $error("masked level taken");
    a_soft_taken: assert property (level_ack_i && level_service_instruction_i |=> ack_taken_o)
        else $error("software request not taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
    c_soft: cover property (level_ack_i && level_service_instruction_i);
    c_taken: cover property (ack_taken_o && level_location_o == 16'h0004);
    c_read: cover property (s_axi_rvalid);
endmodule // pivec_checker

// ==== dv/peripheral_interrupt_vectoring_tb.sv ====
// self-checking bench for the vectoring block
`include "vector_map.vh"
module peripheral_interrupt_vectoring_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, srst_i, nmi_pin_request_i, go, sw, level_ack_i, level_service_instruction_i, br;
    logic [2:0] gn, level_ack_num_i;
    logic [9:0] req;
    logic [5:0] level_mask_register_i, level_request_o;
    logic nmi_request_o, ack_taken_o, irq_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] level_location_o;
    logic [16:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, ctl;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    integer n_errors, checks, seed, i, k;
    core_ack_model cm (.core_clk_i, .srst_i, .go_i(go), .num_i(gn), .sw_i(sw), .ack_o(level_ack_i),
        .num_o(level_ack_num_i), .svc_o(level_service_instruction_i));
    peripheral_interrupt_vectoring uut (.core_clk_i, .srst_i, .external_pin_request_1_i(req[0]),
        .external_pin_request_2_i(req[1]), .external_pin_request_3_i(req[2]), .watchdog_timer_request_i(req[3]),
        .power_drive_fault_request_i(req[4]), .compare_one_request_i(req[5]), .timer_two_period_request_i(req[6]),
        .timer_two_compare_request_i(req[7]), .capture_one_request_i(req[8]), .converter_done_request_i(req[9]),
        .nmi_pin_request_i, .level_mask_register_i, .level_ack_i, .level_ack_num_i, .level_service_instruction_i,
        .level_request_o, .nmi_request_o, .level_location_o, .ack_taken_o, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_o);
    // ========================================
    // expectation functions
    function automatic [15:0] ofs_of(input integer s);
        case (s)
            0: ofs_of = 16'h0002; 1: ofs_of = 16'h0011; 2: ofs_of = 16'h001F; 3: ofs_of = 16'h0010;
            4: ofs_of = 16'h0020; 5: ofs_of = 16'h0021; 6: ofs_of = 16'h002B; 7: ofs_of = 16'h002C;
            8: ofs_of = 16'h0033; default: ofs_of = 16'h0004;
        endcase
    endfunction
    function automatic [2:0] lvl_of(input integer s);
        if (s < 3) lvl_of = ctl[10] ? 3'd0 : 3'd5;
        else lvl_of = (s == 3) ? 3'd0 : (s == 9) ? 3'd5 : 3'((s - 2) / 2);
    endfunction
    function automatic [15:0] reg_of(input [2:0] n);
        reg_of = (n == 1) ? 16'h7432 : (n == 2) ? 16'h7434 : (n == 3) ? 16'h7431 : 16'h701E;
    endfunction
    // ========================================
    // bus and check tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] x, input [31:0] v);
        @(posedge core_clk_i);
        s_axi_awaddr <= {x[14:0], 2'b00};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid));
        br = s_axi_bresp[1];
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [15:0] x);
        @(posedge core_clk_i);
        s_axi_araddr <= {x[14:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge core_clk_i);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task serve(input [9:0] r, input [2:0] n, input s, input [15:0] e);
        @(posedge core_clk_i);
        req <= r;
        wr(`IDX_CONTROL, ctl);
        go <= 1'b1;
        gn <= n;
        sw <= s;
        @(posedge core_clk_i);
        go <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rd(reg_of(n));
        chk(d, {16'h0000, e});
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_errors = n_errors + 1;
        test_done;
    end
    initial begin
        {srst_i, nmi_pin_request_i, go, sw, gn, req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {n_errors, checks} = 0;
        s_axi_wstrb = 4'hF;
        level_mask_register_i = 6'h3F;
        seed = 2562;
        ctl = 32'h0000_0000;
        srst_i = 1'b1;
        repeat (5) @(posedge core_clk_i);
        srst_i <= 1'b0;
        // reset values, unmapped and read-only places
        for (i = 0; i < 6; i++) begin
            rd(reg_of(3'(i)));
            chk(d, 32'h0000_0000);
        end
        rd(`IDX_CONTROL);
        chk(d, 32'h0000_0200);
        rd(16'h7450);
        chk({30'h0, rs}, 32'h0000_0002);
        wr(16'h701E, 32'h0000_1234);
        chk({31'h0, br}, 32'h0000_0001);
        wr(`IDX_IRQ_MASK, 32'h0000_0000);
        $display("registers done");
        // random sources with random pin routing
        for (i = 0; i < 24; i++) begin
            k = $unsigned($random(seed)) % 10;
            ctl = {21'h0, 1'($random(seed)), 10'h0};
            serve(10'h001 << k, lvl_of(k), 1'b0, ofs_of(k));
        end
        ctl = 32'h0000_0400;
        serve(10'h00E, 3'd0, 1'b0, 16'h0011);
        rd(`IDX_PENDING);
        chk(d, 32'h0000_000E);
        serve(10'h030, 3'd1, 1'b0, 16'h0020);
        serve(10'h020, 3'd1, 1'b0, 16'h0021);
        serve(10'h0C0, 3'd2, 1'b0, 16'h002B);
        // masked level, then global mask still set
        level_mask_register_i <= 6'h3D;
        serve(10'h010, 3'd1, 1'b0, 16'h0021);
        level_mask_register_i <= 6'h3F;
        ctl = 32'h0000_0200;
        serve(10'h010, 3'd1, 1'b0, 16'h0021);
        for (i = 0; i < 6; i++) serve(10'h010, 3'(i), 1'b1, 16'h0000);
        ctl = 32'h0000_0000;
        req <= 10'h100;
        repeat (2) @(posedge core_clk_i);
        serve(10'h000, 3'd3, 1'b0, 16'h0000);
        serve(10'h000, 3'd1, 1'b0, 16'h0000);
        serve(10'h201, 3'd5, 1'b0, 16'h0004);
        $display("vectors done");
        // status, mask and clear of the interrupt
        rd(`IDX_IRQ_STATUS);
        serve(10'h040, 3'd2, 1'b0, 16'h002B);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wr(`IDX_IRQ_MASK, 32'h0000_0007);
        repeat (3) @(posedge core_clk_i);
        chk({31'h0, irq_o}, 32'h0000_0001);
        rd(`IDX_IRQ_STATUS);
        chk(d, 32'h0000_0003);
        repeat (3) @(posedge core_clk_i);
        chk({31'h0, irq_o}, 32'h0000_0000);
        nmi_pin_request_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        chk({16'h0, level_location_o}, 32'h0000_0024);
        nmi_pin_request_i <= 1'b0;
        $display("interrupt done");
        test_done;
    end
endmodule // peripheral_interrupt_vectoring_tb
bind peripheral_interrupt_vectoring pivec_checker chk_i (.core_clk_i, .srst_i, .power_drive_fault_request_i,
    .compare_one_request_i, .timer_two_period_request_i, .timer_two_compare_request_i, .capture_one_request_i,
    .nmi_pin_request_i, .level_mask_register_i, .level_ack_i, .level_ack_num_i, .level_service_instruction_i,
    .level_request_o, .nmi_request_o, .level_location_o, .ack_taken_o, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ==== include/vector_map.vh ====
// register offsets, vector offsets and field positions for the interrupt vectoring block
`ifndef VECTOR_MAP_VH
`define VECTOR_MAP_VH

// ===========================================================================
// register indices (printed offsets are word indices)
`define IDX_SYSTEM_VECTOR 16'h701E
`define IDX_GROUP_C_VECTOR 16'h7431
`define IDX_GROUP_A_VECTOR 16'h7432
`define IDX_GROUP_B_VECTOR 16'h7434
`define IDX_CONTROL 16'h7440
`define IDX_IRQ_STATUS 16'h7441
`define IDX_IRQ_MASK 16'h7442
`define IDX_PENDING 16'h7443

// ===========================================================================
// core vector locations
`define LOC_NMI 16'h0024
`define LOC_LEVEL_ONE 16'h0002
`define LOC_LEVEL_SIX 16'h000C
`define LOC_STEP 16'h0002

// ===========================================================================
// peripheral vector offsets
`define VEC_PHANTOM 16'h0000
`define VEC_PIN_1 16'h0002
`define VEC_PIN_2 16'h0011
`define VEC_PIN_3 16'h001F
`define VEC_WATCHDOG 16'h0010
`define VEC_POWER_FAULT 16'h0020
`define VEC_COMPARE_1 16'h0021
`define VEC_TIMER2_PERIOD 16'h002B
`define VEC_TIMER2_COMPARE 16'h002C
`define VEC_CAPTURE_1 16'h0033
`define VEC_CONVERTER 16'h0004

// ===========================================================================
// control register fields and reset values
`define CTL_GLOBAL_MASK_BIT 9
`define CTL_PIN_HIGH_BIT 10
`define CTL_RESET 32'h0000_0200
`define VEC_RESET 16'h0000

// ===========================================================================
// source indices, highest priority first within each level, except that the converter wins over the pins when they share its level
`define SRC_PIN_1 0
`define SRC_PIN_2 1
`define SRC_PIN_3 2
`define SRC_WATCHDOG 3
`define SRC_POWER_FAULT 4
`define SRC_COMPARE_1 5
`define SRC_TIMER2_PERIOD 6
`define SRC_TIMER2_COMPARE 7
`define SRC_CAPTURE_1 8
`define SRC_CONVERTER 9
`define NUM_SOURCES 10

`endif

// ==== rtl/axil_regs.v ====
// axi4-lite slave front end: one write and one read at a time
module axil_regs (
    // clock and reset
    input wire core_clk_i,
    input wire srst_i,
    // write address and data
    input wire [16:0] awaddr_i,
    input wire awvalid_i,
    output reg awready_o,
    input wire [31:0] wdata_i,
    input wire [3:0] wstrb_i,
    input wire wvalid_i,
    output reg wready_o,
    // write response
    output reg [1:0] bresp_o,
    output reg bvalid_o,
    input wire bready_i,
    // read address and data
    input wire [16:0] araddr_i,
    input wire arvalid_i,
    output reg arready_o,
    output reg [31:0] rdata_o,
    output reg [1:0] rresp_o,
    output reg rvalid_o,
    input wire rready_i,
    // register side
    output reg wr_stb_o,
    output reg [14:0] wr_idx_o,
    output reg [31:0] wr_data_o,
    output reg [3:0] wr_strb_o,
    output wire rd_stb_o,
    output wire [14:0] rd_idx_o,
    input wire [31:0] rd_data_i,
    input wire rd_ok_i,
    input wire wr_ok_i
);
    reg aw_have_q;
    reg w_have_q;
    reg [14:0] aw_idx_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // ===================================================================
    // write path
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 15'h0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_o <= 1'b0;
            bresp_o <= 2'b00;
            wr_stb_o <= 1'b0;
            wr_idx_o <= 15'h0000;
            wr_data_o <= 32'h0000_0000;
            wr_strb_o <= 4'h0;
        end else begin
            wr_stb_o <= 1'b0;
            if (awvalid_i && awready_o) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= awaddr_i[16:2];
                awready_o <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata_i;
                w_strb_q <= wstrb_i;
                wready_o <= 1'b0;
            end
            if (aw_have_q && w_have_q && !bvalid_o && !wr_stb_o) begin
                wr_stb_o <= 1'b1;
                wr_idx_o <= aw_idx_q;
                wr_data_o <= w_data_q;
                wr_strb_o <= w_strb_q;
            end
            if (wr_stb_o) begin
                bvalid_o <= 1'b1;
                bresp_o <= wr_ok_i ? 2'b00 : 2'b10;
            end
            if (bvalid_o && bready_i) begin
                bvalid_o <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                awready_o <= 1'b1;
                wready_o <= 1'b1;
            end
        end
    end

    // ===================================================================
    // read path
    assign rd_stb_o = arvalid_i && arready_o;
    assign rd_idx_o = araddr_i[16:2];
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= 2'b00;
        end else begin
            if (rd_stb_o) begin
                arready_o <= 1'b0;
                rvalid_o <= 1'b1;
                rdata_o <= rd_ok_i ? rd_data_i : 32'h0000_0000;
                rresp_o <= rd_ok_i ? 2'b00 : 2'b10;
            end else if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
                arready_o <= 1'b1;
            end
        end
    end
endmodule // axil_regs

// ==== rtl/peripheral_interrupt_vectoring.v ====
// interrupt vectoring: sources to six core levels, vector registers for groups A, B and C and one system vector shared by the other levels
`include "vector_map.vh"

module peripheral_interrupt_vectoring (
    // clock and reset
    input wire core_clk_i,
    input wire srst_i,
    // peripheral request lines
    input wire external_pin_request_1_i,
    input wire external_pin_request_2_i,
    input wire external_pin_request_3_i,
    input wire watchdog_timer_request_i,
    input wire power_drive_fault_request_i,
    input wire compare_one_request_i,
    input wire timer_two_period_request_i,
    input wire timer_two_compare_request_i,
    input wire capture_one_request_i,
    input wire converter_done_request_i,
    input wire nmi_pin_request_i,
    // core side
    input wire [5:0] level_mask_register_i,
    input wire level_ack_i,
    input wire [2:0] level_ack_num_i,
    input wire level_service_instruction_i,
    output reg [5:0] level_request_o,
    output reg nmi_request_o,
    output reg [15:0] level_location_o,
    output reg ack_taken_o,
    // axi4-lite slave
    input wire [16:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [16:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // interrupt
    output reg irq_o
);
    localparam NS = `NUM_SOURCES;

    // ===================================================================
    // state
    reg [NS-1:0] pend_q;
    reg [31:0] ctl_q;
    reg [15:0] sys_vec_q;
    reg [15:0] grp_a_vec_q;
    reg [15:0] grp_b_vec_q;
    reg [15:0] grp_c_vec_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;

    wire wr_stb;
    wire [14:0] wr_idx;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire rd_stb;
    wire [14:0] rd_idx;
    reg [31:0] rd_data;
    reg rd_ok;
    reg wr_ok;

    wire global_mask_bit = ctl_q[`CTL_GLOBAL_MASK_BIT];
    wire pin_high = ctl_q[`CTL_PIN_HIGH_BIT];

    // ===================================================================
    // source to level routing
    wire [NS-1:0] src_in = {converter_done_request_i, capture_one_request_i,
                            timer_two_compare_request_i, timer_two_period_request_i,
                            compare_one_request_i, power_drive_fault_request_i,
                            watchdog_timer_request_i, external_pin_request_3_i,
                            external_pin_request_2_i, external_pin_request_1_i};
    wire [2:0] pin_lvl = pin_high ? 3'd0 : 3'd5;
    reg [2:0] src_lvl [0:NS-1];
    reg [15:0] src_vec [0:NS-1];
    always @* begin
        src_lvl[`SRC_PIN_1] = pin_lvl;
        src_lvl[`SRC_PIN_2] = pin_lvl;
        src_lvl[`SRC_PIN_3] = pin_lvl;
        src_lvl[`SRC_WATCHDOG] = 3'd0;
        src_lvl[`SRC_POWER_FAULT] = 3'd1;
        src_lvl[`SRC_COMPARE_1] = 3'd1;
        src_lvl[`SRC_TIMER2_PERIOD] = 3'd2;
        src_lvl[`SRC_TIMER2_COMPARE] = 3'd2;
        src_lvl[`SRC_CAPTURE_1] = 3'd3;
        src_lvl[`SRC_CONVERTER] = 3'd5;
        src_vec[`SRC_PIN_1] = `VEC_PIN_1;
        src_vec[`SRC_PIN_2] = `VEC_PIN_2;
        src_vec[`SRC_PIN_3] = `VEC_PIN_3;
        src_vec[`SRC_WATCHDOG] = `VEC_WATCHDOG;
        src_vec[`SRC_POWER_FAULT] = `VEC_POWER_FAULT;
        src_vec[`SRC_COMPARE_1] = `VEC_COMPARE_1;
        src_vec[`SRC_TIMER2_PERIOD] = `VEC_TIMER2_PERIOD;
        src_vec[`SRC_TIMER2_COMPARE] = `VEC_TIMER2_COMPARE;
        src_vec[`SRC_CAPTURE_1] = `VEC_CAPTURE_1;
        src_vec[`SRC_CONVERTER] = `VEC_CONVERTER;
    end

    // per source: pending and on acknowledged level
    wire [NS-1:0] on_ack;
    wire [NS-1:0] grant;
    wire any_grant;
    wire conv_on_ack = pend_q[`SRC_CONVERTER] && (src_lvl[`SRC_CONVERTER] == level_ack_num_i);
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1) begin : g_src
            assign on_ack[g] = pend_q[g] && (src_lvl[g] == level_ack_num_i) &&
                               !((g <= `SRC_PIN_3) && conv_on_ack);
        end
    endgenerate

    priority_pick #(
        .N(NS)
    ) u_pick (
        .req_i(on_ack),
        .grant_o(grant),
        .any_o(any_grant)
    );

    reg [15:0] win_vec;
    integer i;
    always @* begin
        win_vec = `VEC_PHANTOM;
        for (i = 0; i < NS; i = i + 1) begin
            if (grant[i]) begin
                win_vec = src_vec[i];
            end
        end
    end

    wire lvl_ok = (level_ack_num_i < 3'd6) && level_mask_register_i[level_ack_num_i];
    wire ack_hw = level_ack_i && !level_service_instruction_i && !global_mask_bit && lvl_ok;
    wire ack_sw = level_ack_i && level_service_instruction_i && (level_ack_num_i < 3'd6);
    wire ack_any = ack_hw || ack_sw;
    wire serve = ack_hw && any_grant;
    wire [15:0] load_vec = serve ? win_vec : `VEC_PHANTOM;
    wire is_grp_a = (level_ack_num_i == 3'd1);
    wire is_grp_b = (level_ack_num_i == 3'd2);
    wire is_grp_c = (level_ack_num_i == 3'd3);

    // ===================================================================
    // pending, vectors, level requests
    reg [5:0] lvl_req_d;
    integer j;
    always @* begin
        lvl_req_d = 6'b00_0000;
        for (j = 0; j < NS; j = j + 1) begin
            if (src_in[j] && src_lvl[j] < 3'd6) begin
                lvl_req_d[src_lvl[j]] = 1'b1;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            pend_q <= {NS{1'b0}};
            sys_vec_q <= `VEC_RESET;
            grp_a_vec_q <= `VEC_RESET;
            grp_b_vec_q <= `VEC_RESET;
            grp_c_vec_q <= `VEC_RESET;
            level_request_o <= 6'b00_0000;
            nmi_request_o <= 1'b0;
            level_location_o <= 16'h0000;
            ack_taken_o <= 1'b0;
        end else begin
            pend_q <= src_in & ~(grant & {NS{serve}});
            level_request_o <= lvl_req_d;
            nmi_request_o <= nmi_pin_request_i;
            ack_taken_o <= ack_any;
            if (ack_any) begin
                level_location_o <= `LOC_LEVEL_ONE + {level_ack_num_i, 1'b0};
                if (is_grp_a) begin
                    grp_a_vec_q <= load_vec;
                end else if (is_grp_b) begin
                    grp_b_vec_q <= load_vec;
                end else if (is_grp_c) begin
                    grp_c_vec_q <= load_vec;
                end else begin
                    sys_vec_q <= load_vec;
                end
            end else if (nmi_pin_request_i) begin
                level_location_o <= `LOC_NMI;
            end
        end
    end

    // ===================================================================
    // register bus
    axil_regs u_bus (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .awaddr_i(s_axi_awaddr),
        .awvalid_i(s_axi_awvalid),
        .awready_o(s_axi_awready),
        .wdata_i(s_axi_wdata),
        .wstrb_i(s_axi_wstrb),
        .wvalid_i(s_axi_wvalid),
        .wready_o(s_axi_wready),
        .bresp_o(s_axi_bresp),
        .bvalid_o(s_axi_bvalid),
        .bready_i(s_axi_bready),
        .araddr_i(s_axi_araddr),
        .arvalid_i(s_axi_arvalid),
        .arready_o(s_axi_arready),
        .rdata_o(s_axi_rdata),
        .rresp_o(s_axi_rresp),
        .rvalid_o(s_axi_rvalid),
        .rready_i(s_axi_rready),
        .wr_stb_o(wr_stb),
        .wr_idx_o(wr_idx),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .rd_stb_o(rd_stb),
        .rd_idx_o(rd_idx),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok),
        .wr_ok_i(wr_ok)
    );

    always @* begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case ({1'b0, rd_idx})
            `IDX_SYSTEM_VECTOR: rd_data = {16'h0000, sys_vec_q};
            `IDX_GROUP_A_VECTOR: rd_data = {16'h0000, grp_a_vec_q};
            `IDX_GROUP_B_VECTOR: rd_data = {16'h0000, grp_b_vec_q};
            `IDX_GROUP_C_VECTOR: rd_data = {16'h0000, grp_c_vec_q};
            `IDX_CONTROL: rd_data = ctl_q;
            `IDX_IRQ_STATUS: rd_data = {29'h0000_0000, irq_stat_q};
            `IDX_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask_q};
            `IDX_PENDING: rd_data = {{(32 - NS){1'b0}}, pend_q};
            default: rd_ok = 1'b0;
        endcase
        case ({1'b0, wr_idx})
            `IDX_CONTROL: wr_ok = 1'b1;
            `IDX_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // ===================================================================
    // control, interrupt status and mask
    wire [2:0] ev = {ack_any && !serve, serve, ack_any};
    wire stat_rd = rd_stb && ({1'b0, rd_idx} == `IDX_IRQ_STATUS);
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ctl_q <= `CTL_RESET;
            irq_stat_q <= 3'b000;
            irq_mask_q <= 3'b000;
            irq_o <= 1'b0;
        end else begin
            if (wr_stb && wr_ok && ({1'b0, wr_idx} == `IDX_CONTROL) && wr_strb[1]) begin
                ctl_q[`CTL_PIN_HIGH_BIT:`CTL_GLOBAL_MASK_BIT] <=
                    wr_data[`CTL_PIN_HIGH_BIT:`CTL_GLOBAL_MASK_BIT];
            end
            // hardware acknowledge sets global mask, wins over write
            if (ack_hw) begin
                ctl_q[`CTL_GLOBAL_MASK_BIT] <= 1'b1;
            end
            if (wr_stb && wr_ok && ({1'b0, wr_idx} == `IDX_IRQ_MASK) && wr_strb[0]) begin
                irq_mask_q <= wr_data[2:0];
            end
            // set wins over read clear
            irq_stat_q <= (stat_rd ? 3'b000 : irq_stat_q) | ev;
            irq_o <= |(((stat_rd ? 3'b000 : irq_stat_q) | ev) & irq_mask_q);
        end
    end
endmodule // peripheral_interrupt_vectoring

// ==== rtl/priority_pick.v ====
// fixed priority picker: lowest set index wins
module priority_pick #(
    parameter N = 10
) (
    // request bits
    input wire [N-1:0] req_i,
    // one-hot grant and any flag
    output reg [N-1:0] grant_o,
    output reg any_o
);
    integer k;
    reg found;
    always @* begin
        found = 1'b0;
        grant_o = {N{1'b0}};
        for (k = 0; k < N; k = k + 1) begin
            if (req_i[k] && !found) begin
                grant_o[k] = 1'b1;
                found = 1'b1;
            end
        end
        any_o = found;
    end
endmodule // priority_pick
